// >>> twc_consts.svh
// Offsets, field positions, reset values and codes of the two-wire controller
`ifndef TWC_CONSTS_SVH
`define TWC_CONSTS_SVH
`define TWC_IDX_BRD   8'hB8
`define TWC_IDX_STAT  8'hB9
`define TWC_IDX_OWN   8'hBA
`define TWC_IDX_DATA  8'hBB
`define TWC_IDX_CTRL  8'hBC
`define TWC_B_JOB     7
`define TWC_B_ACK     6
`define TWC_B_STA     5
`define TWC_B_STO     4
`define TWC_B_EN      2
`define TWC_B_IE      0
`define TWC_BRD_RST   8'h00
`define TWC_HALF_BASE 16'h0008
`define TWC_S_NONE    8'hF8
`define TWC_S_BERR    8'h00
`define TWC_S_START   8'h08
`define TWC_S_RSTART  8'h10
`define TWC_S_MT_AACK 8'h18
`define TWC_S_MT_ANAK 8'h20
`define TWC_S_MT_DACK 8'h28
`define TWC_S_MT_DNAK 8'h30
`define TWC_S_LOST    8'h38
`define TWC_S_MR_AACK 8'h40
`define TWC_S_MR_ANAK 8'h48
`define TWC_S_MR_DACK 8'h50
`define TWC_S_MR_DNAK 8'h58
`define TWC_S_SR_ADR  8'h60
`define TWC_S_SR_LADR 8'h68
`define TWC_S_GC_ADR  8'h70
`define TWC_S_GC_LADR 8'h78
`define TWC_S_SR_DACK 8'h80
`define TWC_S_SR_DNAK 8'h88
`define TWC_S_GC_DACK 8'h90
`define TWC_S_GC_DNAK 8'h98
`define TWC_S_SR_STOP 8'hA0
`define TWC_S_ST_ADR  8'hA8
`define TWC_S_ST_LADR 8'hB0
`define TWC_S_ST_DACK 8'hB8
`define TWC_S_ST_DNAK 8'hC0
`endif

// >>> twc_pkg.sv
// Types of the two-wire controller and its bus peer
package twc_pkg;
    typedef enum logic [2:0] {S_IDLE, S_START, S_XFER, S_HOLD, S_STOP}
        twc_state_e;
    typedef struct packed {
        twc_state_e  st;
        logic        job, ack_en, sta, sto, wc, en, ie;
        logic [7:0]  brd, own, sh, stat;
        logic [1:0]  ps, ph;
        logic [3:0]  cnt;
        logic        mst, tx, addr, rd, gc, lost, fin, berr, rep;
        logic        ackin, ackout, rose, busy;
        logic [15:0] tmr;
        logic        scl_p, sda_p, scl_oe, sda_oe, wb_ack;
        logic [31:0] wb_dat;
    } twc_ctl_s;
    typedef enum logic [1:0] {P_IDLE, P_START, P_BIT, P_STOP} twc_pst_e;
    typedef struct packed {
        twc_pst_e    st;
        logic [1:0]  ph;
        logic [15:0] tmr;
        logic        scl_oe, sda_oe, own, bitv, done;
    } twc_peer_s;
endpackage

// >>> twc_bus_if.sv
// Two-wire bus between the controller and a peer, open drain resolved
`timescale 1ns/1ps
interface twc_bus_if;
    logic dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe;
    logic peer_scl_o, peer_scl_oe, peer_sda_o, peer_sda_oe;
    logic scl;
    logic sda;
    // Wired AND with pull-up
    assign scl = !((dev_scl_oe && !dev_scl_o) || (peer_scl_oe && !peer_scl_o));
    assign sda = !((dev_sda_oe && !dev_sda_o) || (peer_sda_oe && !peer_sda_o));
    modport dev  (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
                  input scl, sda);
    modport peer (output peer_scl_o, peer_scl_oe, peer_sda_o, peer_sda_oe,
                  input scl, sda);
endinterface

// >>> twc_peer.sv
// Bit-level bus agent standing for other masters and slaves
`timescale 1ns/1ps
`include "twc_consts.svh"
module twc_peer import twc_pkg::*; #(
    parameter int HALF = 16
) (
    input  wire logic     clk_i,        // system clock
    input  wire logic     rst_i,        // sync reset, high
    input  wire logic     cmd_valid_i,  // command request
    input  wire twc_pst_e cmd_i,        // P_START, P_BIT or P_STOP
    input  wire logic     bit_i,        // bit to send, 1 releases
    input  wire logic     hold_scl_i,   // stretch clock when not owner
    input  wire logic     pull_sda_i,   // pull data low when not owner
    output logic          cmd_ready_o,  // accepting commands
    output logic          done_o,       // command finished pulse
    output logic          bit_o,        // bit sampled at clock high
    twc_bus_if.peer       bus           // shared bus
);
    localparam logic [15:0] HALF_M1 = 16'(HALF - 1);
    twc_peer_s q, n;
    logic      last;
    logic [1:0] np;

    always_comb begin
        n = q;
        n.done = 1'b0;
        np = q.ph + 2'd1;
        last = (q.st == P_START && q.ph == 2'd3) ||
               (q.st == P_BIT && q.ph == 2'd1) ||
               (q.st == P_STOP && q.ph == 2'd2);
        unique case (q.st)
            P_IDLE: begin
                if (!q.own) begin
                    n.scl_oe = hold_scl_i;
                    n.sda_oe = pull_sda_i;
                end
                if (cmd_valid_i && cmd_i != P_IDLE) begin
                    n.st = cmd_i;
                    n.ph = 2'd0;
                    n.tmr = 16'd0;
                    n.sda_oe = (cmd_i == P_BIT) ? !bit_i : (cmd_i == P_STOP);
                end
            end
            default: begin
                if (q.ph != 2'd1 || bus.scl) begin
                    n.tmr = q.tmr + 16'd1;
                end
                if (q.tmr >= HALF_M1 && (q.ph != 2'd1 || bus.scl)) begin
                    n.tmr = 16'd0;
                    if (last) begin
                        n.st = P_IDLE;
                        n.done = 1'b1;
                        if (q.st == P_BIT) begin
                            n.bitv = bus.sda;
                            n.scl_oe = 1'b1;
                        end
                        n.own = (q.st != P_STOP);
                    end else begin
                        n.ph = np;
                        if (np == 2'd1) begin
                            n.scl_oe = 1'b0;
                        end else if (q.st == P_START) begin
                            if (np == 2'd2) begin
                                n.sda_oe = 1'b1;
                            end else begin
                                n.scl_oe = 1'b1;
                            end
                        end else begin
                            n.sda_oe = 1'b0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign cmd_ready_o     = (q.st == P_IDLE);
    assign done_o          = q.done;
    assign bit_o           = q.bitv;
    assign bus.peer_scl_o  = 1'b0;
    assign bus.peer_sda_o  = 1'b0;
    assign bus.peer_scl_oe = q.scl_oe;
    assign bus.peer_sda_oe = q.sda_oe;
endmodule

// >>> twc_ctrl.sv
// Two-wire bus controller with Wishbone register access
`timescale 1ns/1ps
`include "twc_consts.svh"
module twc_ctrl import twc_pkg::*; (
    input  wire logic        clk_i,     // system clock
    input  wire logic        rst_i,     // sync reset, high
    input  wire logic [11:0] wb_adr_i,  // byte address
    input  wire logic [31:0] wb_dat_i,  // write data
    input  wire logic        wb_we_i,   // write enable
    input  wire logic [3:0]  wb_sel_i,  // byte lanes
    input  wire logic        wb_cyc_i,  // cycle
    input  wire logic        wb_stb_i,  // strobe
    output logic [31:0]      wb_dat_o,  // read data
    output logic             wb_ack_o,  // acknowledge
    input  wire logic        gie_i,     // global interrupt enable
    output logic             irq_o,     // interrupt request
    twc_bus_if.dev           bus        // shared bus
);
    twc_ctl_s   q, n;
    logic       rise, fall, stt, stp, wr, req, tick, ownm, gcm;
    logic [7:0] sv;
    logic [15:0] hf;

    function automatic logic [15:0] half_cnt(input logic [7:0] d,
                                             input logic [1:0] p);
        half_cnt = `TWC_HALF_BASE + ({8'h00, d} << {p, 1'b0});
    endfunction

    function automatic logic [7:0] code_of(input twc_ctl_s s);
        if (s.mst) begin
            if (s.addr && s.rd) begin
                code_of = s.ackin ? `TWC_S_MR_AACK : `TWC_S_MR_ANAK;
            end else if (s.addr) begin
                code_of = s.ackin ? `TWC_S_MT_AACK : `TWC_S_MT_ANAK;
            end else if (s.tx) begin
                code_of = s.ackin ? `TWC_S_MT_DACK : `TWC_S_MT_DNAK;
            end else begin
                code_of = s.ackout ? `TWC_S_MR_DACK : `TWC_S_MR_DNAK;
            end
        end else if (s.addr) begin
            if (s.rd) begin
                code_of = s.lost ? `TWC_S_ST_LADR : `TWC_S_ST_ADR;
            end else if (s.gc) begin
                code_of = s.lost ? `TWC_S_GC_LADR : `TWC_S_GC_ADR;
            end else begin
                code_of = s.lost ? `TWC_S_SR_LADR : `TWC_S_SR_ADR;
            end
        end else if (s.lost) begin
            code_of = `TWC_S_LOST;
        end else if (s.tx) begin
            code_of = s.ackin ? `TWC_S_ST_DACK : `TWC_S_ST_DNAK;
        end else if (s.gc) begin
            code_of = s.ackout ? `TWC_S_GC_DACK : `TWC_S_GC_DNAK;
        end else begin
            code_of = s.ackout ? `TWC_S_SR_DACK : `TWC_S_SR_DNAK;
        end
    endfunction

    always_comb begin
        n = q;
        rise = bus.scl && !q.scl_p;
        fall = !bus.scl && q.scl_p;
        stt = bus.scl && q.scl_p && q.sda_p && !bus.sda;
        stp = bus.scl && q.scl_p && !q.sda_p && bus.sda;
        n.scl_p = bus.scl;
        n.sda_p = bus.sda;
        if (stt) begin
            n.busy = 1'b1;
        end
        if (stp) begin
            n.busy = 1'b0;
        end
        hf = half_cnt(q.brd, q.ps);
        tick = (q.tmr >= hf);
        ownm = (q.sh[7:1] == q.own[7:1]);
        gcm = (q.sh[7:1] == 7'h00) && q.own[0];
        sv = q.job ? q.stat : `TWC_S_NONE;
        req = wb_cyc_i && wb_stb_i;
        n.wb_ack = req && !q.wb_ack;
        if (req && !q.wb_ack) begin
            unique case (wb_adr_i[11:2])
                {2'b00, `TWC_IDX_BRD}:  n.wb_dat = {24'h0, q.brd};
                {2'b00, `TWC_IDX_STAT}: n.wb_dat = {24'h0, sv[7:3], 1'b0, q.ps};
                {2'b00, `TWC_IDX_OWN}:  n.wb_dat = {24'h0, q.own};
                {2'b00, `TWC_IDX_DATA}: n.wb_dat = {24'h0, q.sh};
                {2'b00, `TWC_IDX_CTRL}: n.wb_dat = {24'h0, q.job, q.ack_en,
                    q.sta, q.sto, q.wc, q.en, 1'b0, q.ie};
                default:                n.wb_dat = 32'h0;
            endcase
        end
        wr = req && q.wb_ack && wb_we_i && wb_sel_i[0];
        if (wr) begin
            unique case (wb_adr_i[11:2])
                {2'b00, `TWC_IDX_BRD}:  n.brd = wb_dat_i[7:0];
                {2'b00, `TWC_IDX_STAT}: n.ps = wb_dat_i[1:0];
                {2'b00, `TWC_IDX_OWN}:  n.own = wb_dat_i[7:0];
                {2'b00, `TWC_IDX_DATA}: begin
                    n.wc = !q.job;
                    if (q.job) begin
                        n.sh = wb_dat_i[7:0];
                    end
                end
                {2'b00, `TWC_IDX_CTRL}: begin
                    n.ack_en = wb_dat_i[`TWC_B_ACK];
                    n.sta = wb_dat_i[`TWC_B_STA];
                    n.sto = q.sto || wb_dat_i[`TWC_B_STO];
                    n.en = wb_dat_i[`TWC_B_EN];
                    n.ie = wb_dat_i[`TWC_B_IE];
                    if (wb_dat_i[`TWC_B_JOB]) begin
                        n.job = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        unique case (q.st)
            S_IDLE: begin
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                n.mst = 1'b0;
                if (stt) begin
                    n.st = S_XFER;
                    n.cnt = 4'd0;
                    {n.tx, n.addr, n.rose, n.lost, n.gc} = 5'b01000;
                end else if (q.sta && !q.busy) begin
                    n.st = S_START;
                    n.ph = 2'd0;
                    n.tmr = 16'd0;
                end
            end
            S_START: begin
                n.tmr = tick ? 16'd0 : q.tmr + 16'd1;
                if (q.ph == 2'd0) begin
                    n.sda_oe = 1'b0;
                    if (tick) begin
                        n.ph = 2'd1;
                        n.scl_oe = 1'b0;
                    end
                end else if (q.ph == 2'd1) begin
                    if (!bus.scl) begin
                        n.tmr = 16'd0;
                    end else if (tick) begin
                        n.ph = 2'd2;
                        n.sda_oe = 1'b1;
                    end
                end else if (tick) begin
                    n.scl_oe = 1'b1;
                    n.st = S_HOLD;
                    n.job = 1'b1;
                    n.stat = q.rep ? `TWC_S_RSTART : `TWC_S_START;
                    {n.mst, n.addr, n.tx, n.lost, n.fin, n.rep} = 6'b111000;
                    n.cnt = 4'd0;
                end
            end
            S_XFER: begin
                if ((stt || stp) && (q.mst || q.rose || q.cnt != 4'd0)) begin
                    // misplaced condition is a bus error
                    n.stat = `TWC_S_BERR;
                    n.job = 1'b1;
                    {n.berr, n.mst, n.scl_oe, n.sda_oe} = 4'b1000;
                    n.st = S_HOLD;
                end else if (stt || stp) begin
                    if (q.addr) begin
                        n.st = stt ? S_XFER : S_IDLE;
                    end else begin
                        n.stat = `TWC_S_SR_STOP;
                        n.job = 1'b1;
                        {n.fin, n.scl_oe, n.sda_oe} = 3'b100;
                        n.st = S_HOLD;
                    end
                end else begin
                    if (q.mst) begin
                        if (q.scl_oe || bus.scl) begin
                            n.tmr = q.tmr + 16'd1;
                        end
                        if (tick && (q.scl_oe || bus.scl)) begin
                            n.tmr = 16'd0;
                            n.scl_oe = !q.scl_oe;
                        end
                    end
                    if (rise) begin
                        n.rose = 1'b1;
                        if (q.cnt < 4'd8) begin
                            n.sh = {q.sh[6:0], bus.sda};
                            if (q.mst && q.tx && !q.sda_oe && !bus.sda) begin
                                {n.lost, n.mst, n.tx} = 3'b100;
                                {n.scl_oe, n.sda_oe} = 2'b00;
                            end
                        end else begin
                            n.ackin = !bus.sda;
                        end
                    end
                    if (fall) begin
                        n.rose = 1'b0;
                        if (q.cnt == 4'd8) begin
                            n.stat = code_of(q);
                            n.job = 1'b1;
                            n.cnt = 4'd0;
                            n.st = S_HOLD;
                            n.addr = 1'b0;
                            n.sda_oe = 1'b0;
                            if (q.addr) begin
                                n.tx = q.mst ? !q.rd : q.rd;
                            end
                            n.fin = !q.mst && !q.addr &&
                                (q.lost || (q.tx ? !q.ackin : !q.ackout));
                            n.scl_oe = !n.fin;
                        end else begin
                            n.cnt = q.cnt + 4'd1;
                            n.sda_oe = q.tx && !q.sh[7];
                            if (q.cnt == 4'd7) begin
                                if (q.addr) begin
                                    n.rd = q.sh[0];
                                end
                                if (q.tx) begin
                                    n.sda_oe = 1'b0;
                                end else if (q.addr && !q.mst) begin
                                    if ((ownm || gcm) && q.ack_en) begin
                                        {n.sda_oe, n.ackout} = 2'b11;
                                        n.gc = gcm && !ownm;
                                    end else if (q.lost) begin
                                        n.stat = `TWC_S_LOST;
                                        n.job = 1'b1;
                                        n.st = S_HOLD;
                                        {n.fin, n.cnt} = {1'b1, 4'd0};
                                        n.addr = 1'b0;
                                    end else begin
                                        n.st = S_IDLE;
                                    end
                                end else begin
                                    n.ackout = q.ack_en;
                                    n.sda_oe = q.ack_en;
                                end
                            end
                        end
                    end
                end
            end
            S_HOLD: begin
                if (!q.job) begin
                    n.tmr = 16'd0;
                    n.rose = 1'b0;
                    if (q.berr || !q.mst) begin
                        n.lost = 1'b0;
                        if (q.sto) begin
                            n.sto = 1'b0;
                            n.st = S_IDLE;
                            {n.berr, n.scl_oe, n.sda_oe} = 3'b000;
                        end else if (q.berr || q.fin) begin
                            // retry from idle if start requested
                            n.berr = 1'b0;
                            n.st = S_IDLE;
                        end else begin
                            n.st = S_XFER;
                            n.scl_oe = 1'b0;
                            n.sda_oe = q.tx && !q.sh[7];
                        end
                    end else if (q.sta) begin
                        n.st = S_START;
                        {n.rep, n.ph} = {1'b1, 2'd0};
                    end else if (q.sto) begin
                        n.st = S_STOP;
                        n.ph = 2'd0;
                    end else begin
                        n.st = S_XFER;
                        n.sda_oe = q.tx && !q.sh[7];
                    end
                end
            end
            S_STOP: begin
                n.tmr = tick ? 16'd0 : q.tmr + 16'd1;
                if (q.ph == 2'd0) begin
                    n.sda_oe = 1'b1;
                    if (tick) begin
                        {n.ph, n.scl_oe} = {2'd1, 1'b0};
                    end
                end else if (q.ph == 2'd1) begin
                    if (!bus.scl) begin
                        n.tmr = 16'd0;
                    end else if (tick) begin
                        {n.ph, n.sda_oe} = {2'd2, 1'b0};
                    end
                end else if (tick) begin
                    {n.sto, n.mst} = 2'b00;
                    n.st = S_IDLE;
                end
            end
        endcase
        if (!q.en) begin
            n.st = S_IDLE;
            {n.scl_oe, n.sda_oe, n.mst} = 3'b000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.brd <= `TWC_BRD_RST;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign irq_o          = q.job && q.ie && gie_i;
    assign wb_ack_o       = q.wb_ack;
    assign wb_dat_o       = q.wb_dat;
    assign bus.dev_scl_o  = 1'b0;
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_scl_oe = q.scl_oe;
    assign bus.dev_sda_oe = q.sda_oe;
endmodule

// >>> twc_asserts.sv
// Bus and register-port checks for the two-wire controller pair
`timescale 1ns/1ps
module twc_asserts (
    input wire logic clk_i,      // clock
    input wire logic rst_i,      // reset
    input wire logic gie_i,      // global irq enable
    input wire logic irq_o,      // irq
    input wire logic wb_cyc_i,   // cycle
    input wire logic wb_stb_i,   // strobe
    input wire logic wb_ack_o,   // ack
    input wire logic dev_scl_oe, // device clock pull
    input wire logic dev_sda_oe, // device data pull
    input wire logic scl,        // clock line
    input wire logic sda         // data line
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence start_seen;
        $rose(dev_sda_oe) && scl;
    endsequence
    sequence clk_kept;
        !dev_scl_oe [*4];
    endsequence
    scl_pull_low_a: assert property (dev_scl_oe |-> !scl)
        else $error("clock pull not seen");
    sda_pull_low_a: assert property (dev_sda_oe |-> !sda)
        else $error("data pull not seen");
    reset_release_a: assert property ($fell(rst_i) |->
        !dev_scl_oe && !dev_sda_oe)
        else $error("lines driven after reset");
    start_keep_a: assert property (start_seen |-> clk_kept)
        else $error("clock pulled during start");
    irq_gate_a: assert property (irq_o |-> gie_i)
        else $error("irq without global enable");
    flag_clear_a: assert property ($fell(irq_o) && gie_i &&
        $past(gie_i) |-> $past(wb_ack_o))
        else $error("irq fell without a write");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
endmodule

// >>> two_wire_bus_control_and_arbitration_tb.sv
// Testbench joining controller and peer over the two-wire bus
`timescale 1ns/1ps
module two_wire_bus_control_and_arbitration_tb import twc_pkg::*;;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", n, e, g); end end
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, gie = 1, wb_ack, irq;
    logic pv = 0, p_rdy, p_done;
    logic [11:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    twc_pst_e pc = P_IDLE;
    int bad_count = 0, checks_done = 0;
    logic [7:0] q;
    always #25 clk_i = ~clk_i;
    twc_bus_if bus_if();
    twc_ctrl twc_ctrl_inst(.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .gie_i(gie),
        .irq_o(irq), .bus(bus_if));
    twc_peer #(.HALF(8)) twc_peer_inst(.clk_i(clk_i), .rst_i(rst_i),
        .cmd_valid_i(pv), .cmd_i(pc), .bit_i(1'b1), .hold_scl_i(1'b0),
        .pull_sda_i(1'b0), .cmd_ready_o(p_rdy), .done_o(p_done), .bit_o(),
        .bus(bus_if));
    twc_asserts twc_asserts_inst(.clk_i(clk_i), .rst_i(rst_i), .gie_i(gie),
        .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack),
        .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_oe(bus_if.dev_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= {2'b00, idx, 2'b00}; we <= w; wdat <= {24'h0, d};
        cyc <= 1; stb <= 1;
        do @(posedge clk_i); while (wb_ack !== 1'b1 && ++n < 100);
        q = rdat[7:0];
        cyc <= 0; stb <= 0;
        `CHK("ack", 1'b1, wb_ack)
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        wb(0, idx, 8'h00);
        `CHK("reg", e, q)
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 4000) begin
            @(posedge clk_i); n++;
        end
        `CHK("irq wait", 1'b1, irq)
    endtask
    task automatic pcmd(input twc_pst_e c);
        int n;
        n = 0;
        @(posedge clk_i);
        pv <= 1; pc <= c;
        do @(posedge clk_i); while (p_rdy !== 1'b1 && ++n < 100);
        pv <= 0;
        while (p_done !== 1'b1 && n < 2000) begin
            @(posedge clk_i); n++;
        end
        `CHK("peer done", 1'b1, p_done)
    endtask
    task automatic t_regs();
        rd(8'hB8, 8'h00);
        rd(8'hB9, 8'hF8);
        rd(8'hBC, 8'h00);
        rd(8'h10, 8'h00);
        wb(1, 8'hB8, 8'hA5);
        rd(8'hB8, 8'hA5);
        wb(1, 8'hB9, 8'h03);
        rd(8'hB9, 8'hFB);
        wb(1, 8'hB9, 8'h00);
        wb(1, 8'hB8, 8'h0A);
    endtask
    task automatic t_start();
        `CHK("irq idle", 1'b0, irq)
        wb(1, 8'hBC, 8'h25);
        wait_irq();
        rd(8'hB9, 8'h08);
        rd(8'hBC, 8'hA5);
        `CHK("scl held", 1'b0, bus_if.scl)
        gie <= 0;
        repeat (2) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq)
        gie <= 1;
        repeat (2) @(posedge clk_i);
        `CHK("irq kept", 1'b1, irq)
    endtask
    task automatic t_berr();
        wb(1, 8'hBB, 8'hFE);
        wb(1, 8'hBC, 8'h85);
        pcmd(P_START);
        wait_irq();
        rd(8'hB9, 8'h00);
        `CHK("irq error", 1'b1, irq)
        `CHK("lines free", 2'b00, {bus_if.dev_scl_oe, bus_if.dev_sda_oe})
        pcmd(P_STOP);
        wb(1, 8'hBC, 8'hD5);
        rd(8'hBC, 8'h45);
        rd(8'hB9, 8'hF8);
        `CHK("no stop", 2'b00, {bus_if.dev_scl_oe, bus_if.dev_sda_oe})
    endtask
    task automatic t_stop();
        wb(1, 8'hBC, 8'h65);
        wait_irq();
        rd(8'hB9, 8'h08);
        wb(1, 8'hBC, 8'hD5);
        repeat (80) @(posedge clk_i);
        rd(8'hBC, 8'h45);
        `CHK("stop sent", 2'b11, {bus_if.scl, bus_if.sda})
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_start();
        t_berr();
        t_stop();
        stop_test();
    end
    initial begin
        #(50 * 30000);
        bad_count++;
        stop_test();
    end
endmodule
